// *** ebp_pkg.sv ***
// Shared constants for the external bus cycle phaser
package ebp_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_TIMING0 = 8'h00; // Chip-select timing regs, one word each
  localparam logic [7:0] ADDR_CONFIG  = 8'h40;
  localparam logic [7:0] ADDR_STATUS  = 8'h44;
  // Timing register field positions
  localparam int F_AB     = 0;  // Address setup base: 0 -> 1, 1 -> 2 periods
  localparam int F_EXT_LO = 1;  // Window change extension, 2 bits
  localparam int F_CMD_LO = 3;  // Command delay, 2 bits
  localparam int F_DS     = 5;  // Write data setup / mux tristate, 1 bit
  localparam int F_ACC_LO = 6;  // Access length minus one, 5 bits
  localparam int F_HLD_LO = 11; // Hold, 2 bits
  localparam int F_MUX    = 13; // Multiplexed bus mode
  localparam int TIM_W    = 14;
  // Config register field positions
  localparam int F_HALVE  = 0;  // cpu_clock_halving_select
  // Reset values
  localparam logic [TIM_W-1:0] TIM_RST    = 14'h07C1;
  localparam logic             HALVE_RST  = 1'b0;
  // Clock
  localparam int CLK_MHZ  = 250;
  // Phase lengths are held in this many bits
  localparam int LEN_W    = 6;
  // Bus phases
  typedef enum logic [2:0] {PH_IDLE, PH_AB, PH_C, PH_D, PH_E, PH_F} ebp_phase_t;
endpackage

// *** ebp_cpu_tick.sv ***
// CPU clock period marker derived from the master clock
`timescale 1ns/1ps
module ebp_cpu_tick (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // Control
  input  wire logic halve,
  // Marker of a CPU clock period end
  output logic      tick
);
  // Full rate marks every edge, half rate every other edge
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tick <= 1'b1;
    end else begin
      tick <= halve ? ~tick : 1'b1;
    end
  end

  half_rate_a: assert property (@(posedge clk) disable iff (!rstn) (halve && tick) |=> !tick)
    else $error("half rate tick repeated");
  full_rate_a: assert property (@(posedge clk) disable iff (!rstn) !halve |=> tick)
    else $error("full rate tick missing");
endmodule // ebp_cpu_tick

// *** ebp_phaser.sv ***
// External bus cycle sequencer with chip-select timing registers
`timescale 1ns/1ps
module ebp_phaser #(
  parameter int NCS    = 4,
  parameter int ADDR_W = 24,
  parameter int DATA_W = 16
) (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   rstn,
  // Register port
  input  wire logic [7:0]             reg_addr,
  input  wire logic [31:0]            reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic      [31:0]            reg_rdata,
  // Access requests from the bus master
  input  wire logic                   req,
  input  wire logic                   req_we,
  input  wire logic                   req_ube,
  input  wire logic [$clog2(NCS)-1:0] req_cs,
  input  wire logic [ADDR_W-1:0]      req_addr,
  input  wire logic [DATA_W-1:0]      req_wdata,
  output logic                        busy,
  output logic                        done,
  output logic      [DATA_W-1:0]      rdata,
  // External bus pins
  output logic      [ADDR_W-1:0]      bus_addr,
  output logic      [NCS-1:0]         cs_n,
  output logic                        ale,
  output logic                        rd_n,
  output logic                        wr_n,
  output logic                        upper_byte_select_n,
  output logic      [DATA_W-1:0]      data_out,
  output logic                        data_oe,
  input  wire logic [DATA_W-1:0]      data_in
);
  localparam int CS_W = $clog2(NCS);

  ebp_pkg::ebp_phase_t st_r, st_nxt;
  logic [ebp_pkg::TIM_W-1:0] chip_select_timing_regs [NCS];
  logic [ebp_pkg::TIM_W-1:0] tim_r;
  logic                      halve_r;
  logic                      tick;
  logic                      we_r, ube_r, pend_r, chg_r;
  logic [CS_W-1:0]           cs_r, prev_cs_r;
  logic [DATA_W-1:0]         wdata_r, din_s1_r, din_s2_r;
  logic [ebp_pkg::LEN_W-1:0] cnt_r, cnt_nxt;
  logic                      leave;
  logic [ADDR_W-1:0]         req_addr_hold;
  logic [1:0]                leave_r;  // Bus idle marker, delayed past the read sync
  logic [1:0]                cap_r;    // Strobe end marker, delayed to match the sync flops

  // Length of a phase in CPU periods for a given timing word
  function automatic logic [ebp_pkg::LEN_W-1:0] phase_len(input ebp_pkg::ebp_phase_t ph,
                                                          input logic [ebp_pkg::TIM_W-1:0] t,
                                                          input logic chg);
    logic [ebp_pkg::LEN_W-1:0] l;
    l = '0;
    case (ph)
      ebp_pkg::PH_AB: begin
        l = ebp_pkg::LEN_W'(t[ebp_pkg::F_AB]) + 6'h1
          + (chg ? ebp_pkg::LEN_W'(t[ebp_pkg::F_EXT_LO +: 2]) : 6'h0);
      end
      ebp_pkg::PH_C: l = ebp_pkg::LEN_W'(t[ebp_pkg::F_CMD_LO +: 2]);
      ebp_pkg::PH_D: l = ebp_pkg::LEN_W'(t[ebp_pkg::F_DS]);
      ebp_pkg::PH_E: l = ebp_pkg::LEN_W'(t[ebp_pkg::F_ACC_LO +: 5]) + 6'h1;
      ebp_pkg::PH_F: l = ebp_pkg::LEN_W'(t[ebp_pkg::F_HLD_LO +: 2]);
      default: l = '0;
    endcase
    return l;
  endfunction

  // Following phase, skipping phases of zero length
  function automatic ebp_pkg::ebp_phase_t next_ph(input ebp_pkg::ebp_phase_t ph,
                                                  input logic [ebp_pkg::TIM_W-1:0] t);
    ebp_pkg::ebp_phase_t n;
    n = ebp_pkg::PH_IDLE;
    case (ph)
      ebp_pkg::PH_AB: begin
        if (t[ebp_pkg::F_CMD_LO +: 2] != 2'h0) n = ebp_pkg::PH_C;
        else if (t[ebp_pkg::F_DS]) n = ebp_pkg::PH_D;
        else n = ebp_pkg::PH_E;
      end
      ebp_pkg::PH_C: n = t[ebp_pkg::F_DS] ? ebp_pkg::PH_D : ebp_pkg::PH_E;
      ebp_pkg::PH_D: n = ebp_pkg::PH_E;
      ebp_pkg::PH_E: n = (t[ebp_pkg::F_HLD_LO +: 2] != 2'h0) ? ebp_pkg::PH_F : ebp_pkg::PH_IDLE;
      default: n = ebp_pkg::PH_IDLE;
    endcase
    return n;
  endfunction

  // CPU period marker
  ebp_cpu_tick u_tick (
    .clk   (clk),
    .rstn  (rstn),
    .halve (halve_r),
    .tick  (tick)
  );

  // Register writes
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < NCS; i++) chip_select_timing_regs[i] <= ebp_pkg::TIM_RST;
      halve_r <= ebp_pkg::HALVE_RST;
    end else if (reg_wr) begin
      for (int i = 0; i < NCS; i++) begin
        if (reg_addr == ebp_pkg::ADDR_TIMING0 + 8'(4 * i))
          chip_select_timing_regs[i] <= reg_wdata[ebp_pkg::TIM_W-1:0];
      end
      if (reg_addr == ebp_pkg::ADDR_CONFIG) halve_r <= reg_wdata[ebp_pkg::F_HALVE];
    end
  end

  // Register reads, one cycle later
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= '0;
      if (reg_rd) begin
        for (int i = 0; i < NCS; i++) begin
          if (reg_addr == ebp_pkg::ADDR_TIMING0 + 8'(4 * i))
            reg_rdata <= 32'(chip_select_timing_regs[i]);
        end
        if (reg_addr == ebp_pkg::ADDR_CONFIG) reg_rdata <= 32'(halve_r);
        if (reg_addr == ebp_pkg::ADDR_STATUS) reg_rdata <= {24'h0, 1'b0, 3'(st_r), 3'h0, busy};
      end
    end
  end

  // Read data pins pass two flip-flops
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      din_s1_r <= '0;
      din_s2_r <= '0;
    end else begin
      din_s1_r <= data_in;
      din_s2_r <= din_s1_r;
    end
  end

  // Request acceptance and latching
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      busy      <= 1'b0;
      pend_r    <= 1'b0;
      we_r      <= 1'b0;
      ube_r     <= 1'b0;
      chg_r     <= 1'b0;
      cs_r      <= '0;
      prev_cs_r <= '0;
      wdata_r   <= '0;
      tim_r     <= ebp_pkg::TIM_RST;
      done      <= 1'b0;
      leave_r   <= 2'h0;
    end else begin
      leave_r <= {leave_r[0], leave}; // Done waits until the read result has landed
      done    <= leave_r[1];
      if (req && !busy) begin
        busy      <= 1'b1;
        pend_r    <= 1'b1;
        we_r      <= req_we;
        ube_r     <= req_ube;
        cs_r      <= req_cs;
        chg_r     <= (req_cs != prev_cs_r);
        prev_cs_r <= req_cs;
        wdata_r   <= req_wdata;
        tim_r     <= chip_select_timing_regs[req_cs];
      end else begin
        if (st_r == ebp_pkg::PH_IDLE && st_nxt == ebp_pkg::PH_AB) pend_r <= 1'b0;
        if (leave) busy <= 1'b0;
      end
    end
  end

  assign leave = (st_r != ebp_pkg::PH_IDLE) && (st_nxt == ebp_pkg::PH_IDLE);

  // Phase sequencing, advancing only on CPU period ends
  always_comb begin
    ebp_pkg::ebp_phase_t n;
    n       = ebp_pkg::PH_IDLE;
    st_nxt  = st_r;
    cnt_nxt = cnt_r;
    case (st_r)
      ebp_pkg::PH_IDLE: begin
        if (tick && pend_r) begin
          st_nxt  = ebp_pkg::PH_AB;
          cnt_nxt = phase_len(ebp_pkg::PH_AB, tim_r, chg_r) - 6'h1;
        end
      end
      ebp_pkg::PH_AB, ebp_pkg::PH_C, ebp_pkg::PH_D, ebp_pkg::PH_E, ebp_pkg::PH_F: begin
        if (tick) begin
          if (cnt_r == '0) begin
            n       = next_ph(st_r, tim_r);
            st_nxt  = n;
            cnt_nxt = (n == ebp_pkg::PH_IDLE) ? '0 : phase_len(n, tim_r, chg_r) - 6'h1;
          end else begin
            cnt_nxt = cnt_r - 6'h1;
          end
        end
      end
      default: st_nxt = ebp_pkg::PH_IDLE;
    endcase
  end

  // Phase state
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_r  <= ebp_pkg::PH_IDLE;
      cnt_r <= '0;
    end else begin
      st_r  <= st_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // Bus pins follow the coming phase so they change on phase edges
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bus_addr            <= '0;
      cs_n                <= '1;
      ale                 <= 1'b0;
      rd_n                <= 1'b1;
      wr_n                <= 1'b1;
      upper_byte_select_n <= 1'b1;
      data_out            <= '0;
      data_oe             <= 1'b0;
    end else begin
      if (st_nxt == ebp_pkg::PH_AB) bus_addr <= req_addr_hold;
      cs_n                <= (st_nxt != ebp_pkg::PH_IDLE) ? ~(NCS'(1) << cs_r) : '1;
      ale                 <= (st_nxt == ebp_pkg::PH_AB);
      rd_n                <= !(st_nxt == ebp_pkg::PH_E && !we_r);
      wr_n                <= !(st_nxt == ebp_pkg::PH_E && we_r);
      upper_byte_select_n <= !(st_nxt != ebp_pkg::PH_IDLE && ube_r);
      if (tim_r[ebp_pkg::F_MUX] && st_nxt == ebp_pkg::PH_AB) begin
        data_out <= req_addr_hold[DATA_W-1:0];
        data_oe  <= 1'b1;
      end else if (we_r && (st_nxt == ebp_pkg::PH_E || st_nxt == ebp_pkg::PH_F ||
                   (st_nxt == ebp_pkg::PH_D && !tim_r[ebp_pkg::F_MUX]))) begin
        data_out <= wdata_r;
        data_oe  <= 1'b1;
      end else begin
        data_oe  <= 1'b0;
      end
    end
  end

  // Address of the accepted request
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) req_addr_hold <= '0;
    else if (req && !busy) req_addr_hold <= req_addr;
  end

  // Pin value at the edge that raises the read strobe, out of the sync two edges later
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cap_r <= 2'h0;
      rdata <= '0;
    end else begin
      cap_r <= {cap_r[0], (st_r == ebp_pkg::PH_E && st_nxt != ebp_pkg::PH_E && !we_r)};
      if (cap_r[1]) rdata <= din_s2_r;
    end
  end

  // Checking helpers: periods spent and expected in the current phase
  logic [ebp_pkg::LEN_W-1:0] per_r;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) per_r <= '0;
    else if (st_nxt != st_r) per_r <= '0;
    else if (tick && st_r != ebp_pkg::PH_IDLE) per_r <= per_r + 6'h1;
  end
  logic [ebp_pkg::LEN_W-1:0] exp_len;
  assign exp_len = phase_len(st_r, tim_r, chg_r);

  phase_order_a: assert property (@(posedge clk) disable iff (!rstn)
    (st_r != st_nxt && st_r != ebp_pkg::PH_IDLE) |-> (st_nxt > st_r || st_nxt == ebp_pkg::PH_IDLE))
    else $error("bus phase out of order");
  access_len_a: assert property (@(posedge clk) disable iff (!rstn)
    (st_r == ebp_pkg::PH_E && st_nxt != ebp_pkg::PH_E) |-> (per_r + 6'h1 == exp_len && exp_len <= 6'h20))
    else $error("access phase length wrong");
  setup_len_a: assert property (@(posedge clk) disable iff (!rstn)
    (st_r == ebp_pkg::PH_AB && st_nxt != ebp_pkg::PH_AB) |-> (per_r + 6'h1 == exp_len && exp_len <= 6'h5))
    else $error("address setup length wrong");
  window_ext_a: assert property (@(posedge clk) disable iff (!rstn)
    (st_r == ebp_pkg::PH_AB && !chg_r) |-> (exp_len <= 6'h2))
    else $error("setup extended without window change");
  cmd_hold_len_a: assert property (@(posedge clk) disable iff (!rstn)
    ((st_r == ebp_pkg::PH_C || st_r == ebp_pkg::PH_F) && st_nxt != st_r) |-> (per_r + 6'h1 == exp_len))
    else $error("command or hold length wrong");
  data_setup_a: assert property (@(posedge clk) disable iff (!rstn)
    (st_r == ebp_pkg::PH_D) |-> (st_nxt == ebp_pkg::PH_E || !tick))
    else $error("data setup longer than one period");
  tick_only_a: assert property (@(posedge clk) disable iff (!rstn)
    (st_r != st_nxt) |-> tick)
    else $error("phase moved between cpu periods");
  read_capture_a: assert property (@(posedge clk) disable iff (!rstn)
    ($rose(rd_n) && !ale) |-> ##2 (rdata == $past(data_in, 3)))
    else $error("read data not captured at strobe end");
  strobe_span_a: assert property (@(posedge clk) disable iff (!rstn)
    (st_r == ebp_pkg::PH_E) |-> (rd_n == we_r && wr_n == !we_r))
    else $error("strobe not active through access");

  read_cycle_c: cover property (@(posedge clk) disable iff (!rstn) $rose(rd_n) ##[2:8] done);
  write_cycle_c: cover property (@(posedge clk) disable iff (!rstn) $rose(wr_n));
  window_change_c: cover property (@(posedge clk) disable iff (!rstn) st_r == ebp_pkg::PH_AB && exp_len == 6'h5);
  half_rate_c: cover property (@(posedge clk) disable iff (!rstn) halve_r && done);
endmodule // ebp_phaser

// *** ebp_mem_model.sv ***
// Behavioural external memory sitting on the phaser's bus pins
`timescale 1ns/1ps
module ebp_mem_model (
  // Clock
  input  wire logic        clk,
  // Bus pins from the phaser
  input  wire logic [3:0]  cs_n,
  input  wire logic        rd_n,
  input  wire logic        wr_n,
  input  wire logic [23:0] bus_addr,
  input  wire logic [15:0] data_out,
  input  wire logic        data_oe,
  // One extra clock before read data is valid
  input  wire logic        slow,
  // Read data towards the phaser
  output logic      [15:0] data_in
);
  logic [15:0] mem [16];
  logic [15:0] rel_r;
  logic        rd_seen_r;
  logic        sel;
  logic        drive;
  // Drive only while selected and read strobe low
  assign sel     = (cs_n != 4'hF);
  assign drive   = sel && !rd_n && (!slow || rd_seen_r);
  assign data_in = drive ? mem[bus_addr[3:0]] : rel_r;
  // Released bus toggles every cycle; writes land while strobe is low
  always @(posedge clk) begin
    rd_seen_r <= sel && !rd_n;
    rel_r     <= ~data_in;
    if (sel && !wr_n && data_oe) begin
      mem[bus_addr[3:0]] <= data_out;
    end
  end
  // Known start state
  initial begin
    rel_r     = 16'h0000;
    rd_seen_r = 1'b0;
    for (int i = 0; i < 16; i++) mem[i] = 16'h0000;
  end
endmodule // ebp_mem_model

// *** ebp_phaser_tb_top.sv ***
// Self-checking random bench for the external bus cycle phaser
`timescale 1ns/1ps
module ebp_phaser_tb_top;
  localparam int LIMIT = 30000; // Cycle ceiling for the whole run
  logic        clk, rstn, reg_wr, reg_rd, req, req_we, req_ube, slow;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rv;
  logic [1:0]  req_cs, prev_cs;
  logic [23:0] req_addr, bus_addr;
  logic [15:0] req_wdata, rdata, data_out, data_in;
  logic [15:0] shadow [16];
  logic [3:0]  cs_n, cs_seen;
  logic        busy, done, ale, rd_n, wr_n, ube_n, data_oe, seen_str;
  int          error_cnt, n_checks, seed, cyc, c_cs, c_ale, c_mid, c_str, c_post, c_ube;

  ebp_phaser ebp_phaser_inst (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .req(req), .req_we(req_we),
    .req_ube(req_ube), .req_cs(req_cs), .req_addr(req_addr), .req_wdata(req_wdata), .busy(busy),
    .done(done), .rdata(rdata), .bus_addr(bus_addr), .cs_n(cs_n), .ale(ale), .rd_n(rd_n),
    .wr_n(wr_n), .upper_byte_select_n(ube_n), .data_out(data_out), .data_oe(data_oe),
    .data_in(data_in));
  ebp_mem_model ebp_mem_model_inst (.clk(clk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .bus_addr(bus_addr), .data_out(data_out), .data_oe(data_oe), .slow(slow), .data_in(data_in));

  // 250 MHz clock
  always #2 clk = ~clk;

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // Phase lengths seen on the pins during one bus cycle
  always @(posedge clk) begin
    if (req && !busy) begin
      c_cs <= 0; c_ale <= 0; c_mid <= 0; c_str <= 0; c_post <= 0; c_ube <= 0;
      seen_str <= 1'b0;
    end else if (cs_n !== 4'hF) begin
      c_cs    <= c_cs + 1;
      cs_seen <= cs_n;
      c_ale   <= c_ale + int'(ale);
      c_ube   <= c_ube + int'(!ube_n);
      if (!rd_n || !wr_n) begin
        c_str    <= c_str + 1;
        seen_str <= 1'b1;
      end else if (!ale && seen_str) c_post <= c_post + 1;
      else if (!ale) c_mid <= c_mid + 1;
    end
  end

  // One access with a random timing word
  task automatic access(input int i);
    logic [31:0] r, r2;
    logic [3:0]  idx;
    logic        we, halve;
    int          p, setup, total;
    r  = $random(seed);
    r2 = $random(seed);
    we = r[14];
    idx = r2[3:0];
    if (i < 16) begin
      we  = 1'b1;
      idx = i[3:0];
    end
    if (i == 16) r = {12'h000, 2'(prev_cs + 2'd1), 5'h00, 5'h1F, 6'h07}; // Longest setup and access
    if (i == 17) r = 32'h0000_0000; // Shortest cycle
    if (!we && !r[13]) r[5] = 1'b0; // No data setup on demux reads
    halve = r[19];
    p = halve ? 2 : 1;
    slow <= r[18] && ((r[10:6] != 5'h00) || halve);
    setup = (r[0] ? 2 : 1) + ((r[17:16] != prev_cs) ? int'(r[2:1]) : 0);
    total = setup + int'(r[4:3]) + int'(r[5]) + int'(r[10:6]) + 1 + int'(r[12:11]);
    reg_write(ebp_pkg::ADDR_CONFIG, {31'h0, halve});
    reg_write(ebp_pkg::ADDR_TIMING0 + {4'h0, r[17:16], 2'b00}, {18'h0, r[13:0]});
    @(posedge clk);
    req       <= 1'b1;
    req_we    <= we;
    req_ube   <= r[15];
    req_cs    <= r[17:16];
    req_addr  <= {r2[31:12], idx};
    req_wdata <= r2[27:12];
    @(posedge clk);
    req      <= 1'b0;
    reg_rd   <= 1'b1;
    reg_addr <= ebp_pkg::ADDR_STATUS;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 check("busy status", {31'h0, reg_rdata[0]}, 32'h1);
    for (int k = 0; k < 400 && done !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    check("done pulse", {31'h0, done}, 32'h1);
    check("setup length", c_ale, setup * p);
    check("cmd and data setup", c_mid, (int'(r[4:3]) + int'(r[5])) * p);
    check("strobe length", c_str, (int'(r[10:6]) + 1) * p);
    check("hold length", c_post, int'(r[12:11]) * p);
    check("cycle length", c_cs, total * p);
    check("select line", {28'h0, cs_seen}, {28'h0, ~(4'b0001 << r[17:16])});
    check("byte select", c_ube, r[15] ? total * p : 0);
    if (!we) check("read data", {16'h0, rdata}, {16'h0, shadow[idx]});
    else shadow[idx] = r2[27:12];
    prev_cs = r[17:16];
    $display("test access %0d done", i);
  endtask

  // Cycle ceiling
  always @(posedge clk) begin
    cyc++;
    if (cyc >= LIMIT) begin
      error_cnt++;
      $display("ERROR t=%0t run exceeded cycle ceiling", $time);
      final_report();
    end
  end

  // Main sequence
  initial begin
    seed = 43161; error_cnt = 0; n_checks = 0; cyc = 0; prev_cs = 2'd0;
    clk = 1'b0; rstn = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000; req = 1'b0; req_we = 1'b0; req_ube = 1'b0; req_cs = 2'd0;
    req_addr = 24'h00_0000; req_wdata = 16'h0000; slow = 1'b0;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      reg_read({4'h0, k[1:0], 2'b00}, rv);
      check("timing reset", rv, {18'h0, ebp_pkg::TIM_RST});
    end
    reg_read(ebp_pkg::ADDR_CONFIG, rv);
    check("config reset", rv, {31'h0, ebp_pkg::HALVE_RST});
    reg_read(ebp_pkg::ADDR_STATUS, rv);
    check("status idle", rv, 32'h0000_0000);
    reg_write(8'h80, 32'hFFFF_FFFF);
    reg_read(8'h80, rv);
    check("unmapped read", rv, 32'h0000_0000);
    $display("test registers done");
    for (int i = 0; i < 60; i++) access(i);
    final_report();
  end
endmodule // ebp_phaser_tb_top
